// [design/extended_memory_alu_ops.sv]
// Extended-memory ALU datapath: far moves, OR, rotates, subtracts, set and skip forms
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "ext_alu_consts.svh"
// What this block does
// - Load copies memory byte to accumulator, flags untouched
// - Store writes accumulator into memory byte, flags untouched
// - OR of accumulator and byte to either target, only zero flag updated
// - Rotate left moves bit 7 to bit 0, no flags change
// - Accumulator-target rotates write accumulator and leave memory alone
// - Rotate left through carry: bit 7 to carry, carry to bit 0
// - Rotate right moves bit 0 to bit 7, no flags change
// - Rotate right through carry: bit 0 to carry, carry to bit 7
// - Subtract with borrow: accumulator minus byte minus inverted carry
// - Subtraction clears carry when negative, sets it otherwise
// - Subtractions update range, zero, half, carry, sign and chain flags
// - Plain subtract: accumulator minus byte, either target
// - A met skip inserts one dummy cycle, four cycles in all
// - Decrement byte, write back, skip when new value zero
// - Increment byte, write back, skip when zero, flags untouched
// - Accumulator forms of inc/dec skip write only the accumulator
// - Set byte writes all ones, flags untouched
// - Set bit forces the selected bit only
// - Bit test skips when selected bit is one
// - Byte test rewrites the byte and skips when nonzero
// - Full address reaches any memory section
module extended_memory_alu_ops (
  input wire logic clk_sys, // Core clock, 50 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic op_valid, // Sequencer offers an operation
  output logic op_ready, // Datapath idle
  input wire ext_alu_pkg::op_e op_code, // Operation to run
  input wire logic [`EXT_ADDR_W-1:0] op_addr, // Section plus offset address
  input wire logic [2:0] op_bit, // Bit select for bit forms
  output logic op_done, // Operation finished, one cycle
  output logic squash_next, // Dummy cycle, discard next fetch
  output logic [`EXT_ADDR_W-1:0] mem_addr, // Data memory address
  output logic mem_rd, // Read strobe, data next cycle
  input wire logic [7:0] mem_rdata, // Read data
  output logic mem_wr, // Write strobe
  output logic [7:0] mem_wdata, // Write data
  output logic [7:0] accum, // Accumulator
  output logic [`EXT_FLAG_W-1:0] status_flags, // Flag register
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [`EXT_PADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error on unmapped address
);
  import ext_alu_pkg::*;

  typedef struct packed {
    phase_e phase;
    op_e op;
    logic [`EXT_ADDR_W-1:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] acc;
    logic [`EXT_FLAG_W-1:0] flags;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic skip;
    logic [7:0] skip_cnt;
    logic [31:0] rdata;
  } state_s;

  state_s st;
  state_s next_st;
  logic [8:0] diff9;
  logic [4:0] half5;
  logic borrow;
  logic [7:0] res;
  logic [7:0] sub_res;
  logic in_exec;
  logic apb_hit;

  // Handshake and output wiring
  assign in_exec = st.phase == ph_exec;
  assign op_ready = st.phase == ph_idle;
  assign op_done = (st.phase == ph_write && !st.skip) || st.phase == ph_dummy;
  assign squash_next = st.phase == ph_dummy;
  assign mem_addr = st.addr;
  assign mem_rd = st.rd;
  assign mem_wr = st.wr;
  assign mem_wdata = st.wdata;
  assign accum = st.acc;
  assign status_flags = st.flags;
  assign prdata = st.rdata;
  assign pready = 1'b1;

  // Address decode for APB
  always_comb begin
    if (paddr == `EXT_REG_ACCUM) begin
      apb_hit = 1'b1;
    end else if (paddr == `EXT_REG_FLAGS) begin
      apb_hit = 1'b1;
    end else if (paddr == `EXT_REG_STATUS) begin
      apb_hit = 1'b1;
    end else begin
      apb_hit = 1'b0;
    end
  end
  assign pslverr = psel && penable && !apb_hit;

  // Shared subtractor, borrow only for the borrow forms
  always_comb begin
    borrow = 1'b0;
    if (st.op == op_sub_with_borrow_to_accum || st.op == op_sub_with_borrow_to_memory) begin
      borrow = !st.flags[`EXT_FLAG_CARRY];
    end
    diff9 = {1'b0, st.acc} - {1'b0, mem_rdata} - {8'h00, borrow};
    half5 = {1'b0, st.acc[3:0]} - {1'b0, mem_rdata[3:0]} - {4'h0, borrow};
    sub_res = diff9[7:0];
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    res = `EXT_ZERO;
    next_st.rd = 1'b0;
    next_st.wr = 1'b0;
    // APB register access; datapath updates below win on a collision
    if (psel && !penable) begin
      next_st.rdata = 32'h0000_0000;
      if (paddr == `EXT_REG_ACCUM) begin
        next_st.rdata[7:0] = st.acc;
      end else if (paddr == `EXT_REG_FLAGS) begin
        next_st.rdata[`EXT_FLAG_W-1:0] = st.flags;
      end else if (paddr == `EXT_REG_STATUS) begin
        next_st.rdata[`EXT_STAT_BUSY] = st.phase != ph_idle;
        next_st.rdata[`EXT_STAT_SKIP_LO +: 8] = st.skip_cnt;
      end
    end
    if (psel && penable && pwrite) begin
      if (paddr == `EXT_REG_ACCUM) begin
        next_st.acc = pwdata[7:0];
      end else if (paddr == `EXT_REG_FLAGS) begin
        next_st.flags = pwdata[`EXT_FLAG_W-1:0];
      end
    end
    case (st.phase)
      ph_idle: begin
        if (op_valid) begin
          next_st.phase = ph_read;
          next_st.op = op_code;
          next_st.addr = op_addr;
          next_st.bit_sel = op_bit;
          next_st.rd = 1'b1;
          next_st.skip = 1'b0;
        end
      end
      ph_read: begin
        next_st.phase = ph_exec;
      end
      ph_exec: begin
        next_st.phase = ph_write;
        case (st.op)
          op_far_move_load: begin
            next_st.acc = mem_rdata;
          end
          op_far_move_store: begin
            next_st.wr = 1'b1;
            next_st.wdata = st.acc;
          end
          op_far_or_to_accum, op_far_or_to_memory: begin
            res = st.acc | mem_rdata;
            next_st.flags[`EXT_FLAG_ZERO] = res == `EXT_ZERO;
            if (st.op == op_far_or_to_accum) begin
              next_st.acc = res;
            end else begin
              next_st.wr = 1'b1;
              next_st.wdata = res;
            end
          end
          op_rotate_left_byte: begin
            next_st.wr = 1'b1;
            next_st.wdata = {mem_rdata[6:0], mem_rdata[7]};
          end
          op_rotate_left_to_accum: begin
            next_st.acc = {mem_rdata[6:0], mem_rdata[7]};
          end
          op_rotate_left_thru_carry, op_rotate_left_thru_carry_to_accum: begin
            res = {mem_rdata[6:0], st.flags[`EXT_FLAG_CARRY]};
            next_st.flags[`EXT_FLAG_CARRY] = mem_rdata[7];
            if (st.op == op_rotate_left_thru_carry_to_accum) begin
              next_st.acc = res;
            end else begin
              next_st.wr = 1'b1;
              next_st.wdata = res;
            end
          end
          op_rotate_right_byte: begin
            next_st.wr = 1'b1;
            next_st.wdata = {mem_rdata[0], mem_rdata[7:1]};
          end
          op_rotate_right_to_accum: begin
            next_st.acc = {mem_rdata[0], mem_rdata[7:1]};
          end
          op_rotate_right_thru_carry, op_rotate_right_thru_carry_to_accum: begin
            res = {st.flags[`EXT_FLAG_CARRY], mem_rdata[7:1]};
            next_st.flags[`EXT_FLAG_CARRY] = mem_rdata[0];
            if (st.op == op_rotate_right_thru_carry_to_accum) begin
              next_st.acc = res;
            end else begin
              next_st.wr = 1'b1;
              next_st.wdata = res;
            end
          end
          op_sub_with_borrow_to_accum, op_sub_with_borrow_to_memory,
          op_subtract_to_accum, op_subtract_to_memory: begin
            // Carry is the inverted borrow out of the ninth bit
            next_st.flags[`EXT_FLAG_CARRY] = !diff9[8];
            next_st.flags[`EXT_FLAG_HALF] = !half5[4];
            next_st.flags[`EXT_FLAG_ZERO] = sub_res == `EXT_ZERO;
            next_st.flags[`EXT_FLAG_RANGE] = (st.acc[7] ^ mem_rdata[7]) & (st.acc[7] ^ sub_res[7]);
            next_st.flags[`EXT_FLAG_SIGN] = (st.acc[7] ^ mem_rdata[7]) & (st.acc[7] ^ sub_res[7]) ^ sub_res[7];
            if (st.op == op_sub_with_borrow_to_accum || st.op == op_sub_with_borrow_to_memory) begin
              // Chained zero spans a multi-byte subtract
              next_st.flags[`EXT_FLAG_CHAIN] = (sub_res == `EXT_ZERO) & st.flags[`EXT_FLAG_CHAIN];
            end else begin
              next_st.flags[`EXT_FLAG_CHAIN] = sub_res == `EXT_ZERO;
            end
            if (st.op == op_sub_with_borrow_to_accum || st.op == op_subtract_to_accum) begin
              next_st.acc = sub_res;
            end else begin
              next_st.wr = 1'b1;
              next_st.wdata = sub_res;
            end
          end
          op_decrement_skip_zero, op_decrement_skip_zero_to_accum: begin
            res = mem_rdata - `EXT_ONE;
            next_st.skip = res == `EXT_ZERO;
            if (st.op == op_decrement_skip_zero_to_accum) begin
              next_st.acc = res;
            end else begin
              next_st.wr = 1'b1;
              next_st.wdata = res;
            end
          end
          op_increment_skip_zero, op_increment_skip_zero_to_accum: begin
            res = mem_rdata + `EXT_ONE;
            next_st.skip = res == `EXT_ZERO;
            if (st.op == op_increment_skip_zero_to_accum) begin
              next_st.acc = res;
            end else begin
              next_st.wr = 1'b1;
              next_st.wdata = res;
            end
          end
          op_set_byte: begin
            next_st.wr = 1'b1;
            next_st.wdata = `EXT_ALL_ONES;
          end
          op_set_bit: begin
            next_st.wr = 1'b1;
            next_st.wdata = mem_rdata | (`EXT_ONE << st.bit_sel);
          end
          op_skip_if_nonzero_bit: begin
            next_st.skip = mem_rdata[st.bit_sel];
          end
          op_skip_if_nonzero_byte: begin
            next_st.wr = 1'b1;
            next_st.wdata = mem_rdata;
            next_st.skip = mem_rdata != `EXT_ZERO;
          end
          default: begin
            next_st.phase = ph_write;
          end
        endcase
      end
      ph_write: begin
        // A met skip adds the dummy cycle
        next_st.phase = st.skip ? ph_dummy : ph_idle;
        if (st.skip) begin
          next_st.skip_cnt = st.skip_cnt + 8'h01;
        end
      end
      ph_dummy: begin
        next_st.phase = ph_idle;
        next_st.skip = 1'b0;
      end
      default: begin
        next_st.phase = ph_idle;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.acc <= `EXT_ACC_RST;
      st.flags <= `EXT_FLAGS_RST;
    end else begin
      st <= next_st;
    end
  end

  // Checks on the datapath
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_exec_op(op_e o);
    in_exec && st.op == o;
  endsequence

  sequence s_skip_tail;
    st.phase == ph_write && !op_done ##1 squash_next && op_done ##1 op_ready && !squash_next;
  endsequence

  a_load_accum:
    assert property (s_exec_op(op_far_move_load) |=> accum == $past(mem_rdata) && $stable(status_flags) && !mem_wr)
      else $error("load did not copy byte or touched flags");
  a_store_memory:
    assert property (s_exec_op(op_far_move_store) |=> mem_wr && mem_wdata == $past(accum) && $stable(status_flags))
      else $error("store wrong data or flags changed");
  a_or_zero_only:
    assert property (s_exec_op(op_far_or_to_memory) |=>
      mem_wr && mem_wdata == ($past(accum) | $past(mem_rdata))
      && status_flags[`EXT_FLAG_ZERO] == (mem_wdata == `EXT_ZERO)
      && status_flags[`EXT_FLAG_CARRY] == $past(status_flags[`EXT_FLAG_CARRY]))
      else $error("or result or zero flag wrong");
  a_rotate_left:
    assert property (s_exec_op(op_rotate_left_byte) |=>
      mem_wr && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(status_flags))
      else $error("rotate left wrong");
  a_accum_rotate_keeps_memory:
    assert property (s_exec_op(op_rotate_right_to_accum) |=>
      !mem_wr && accum == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
      else $error("accumulator rotate wrote memory");
  a_rotate_carry_left:
    assert property (s_exec_op(op_rotate_left_thru_carry) |=>
      status_flags[`EXT_FLAG_CARRY] == $past(mem_rdata[7])
      && mem_wdata[0] == $past(status_flags[`EXT_FLAG_CARRY]))
      else $error("rotate left through carry wrong");
  a_rotate_right:
    assert property (s_exec_op(op_rotate_right_byte) |=>
      mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && $stable(status_flags))
      else $error("rotate right wrong");
  a_rotate_carry_right:
    assert property (s_exec_op(op_rotate_right_thru_carry) |=>
      status_flags[`EXT_FLAG_CARRY] == $past(mem_rdata[0])
      && mem_wdata[7] == $past(status_flags[`EXT_FLAG_CARRY]))
      else $error("rotate right through carry wrong");
  a_sub_borrow_result:
    assert property (s_exec_op(op_sub_with_borrow_to_accum) |=>
      accum == 8'($past(accum) - $past(mem_rdata) - {7'h00, !$past(status_flags[`EXT_FLAG_CARRY])}))
      else $error("subtract with borrow result wrong");
  a_sub_carry:
    assert property (s_exec_op(op_subtract_to_memory) |=>
      status_flags[`EXT_FLAG_CARRY] == ($past(accum) >= $past(mem_rdata)))
      else $error("subtract carry wrong");
  a_sub_half_zero:
    assert property (s_exec_op(op_subtract_to_accum) |=>
      status_flags[`EXT_FLAG_HALF] == ($past(accum[3:0]) >= $past(mem_rdata[3:0]))
      && status_flags[`EXT_FLAG_CHAIN] == (accum == `EXT_ZERO))
      else $error("subtract half or chain flag wrong");
  a_sub_memory:
    assert property (s_exec_op(op_subtract_to_memory) |=>
      mem_wr && mem_wdata == 8'($past(accum) - $past(mem_rdata)) && $stable(accum))
      else $error("subtract to memory wrong");
  a_skip_three_cycles:
    assert property (in_exec ##1 st.skip |-> s_skip_tail)
      else $error("skip did not insert one dummy cycle");
  a_dec_skip:
    assert property (s_exec_op(op_decrement_skip_zero) && mem_rdata == `EXT_ONE |=> mem_wr && mem_wdata == `EXT_ZERO ##1 squash_next)
      else $error("decrement skip missed");
  a_inc_skip:
    assert property (s_exec_op(op_increment_skip_zero) |=>
      mem_wdata == 8'($past(mem_rdata) + `EXT_ONE) && $stable(status_flags)
      && st.skip == ($past(mem_rdata) == `EXT_ALL_ONES))
      else $error("increment skip wrong");
  a_acc_inc_keeps_memory:
    assert property (s_exec_op(op_increment_skip_zero_to_accum) |=> !mem_wr && st.skip == (accum == `EXT_ZERO))
      else $error("accumulator increment wrote memory");
  a_set_byte:
    assert property (s_exec_op(op_set_byte) |=> mem_wr && mem_wdata == `EXT_ALL_ONES && $stable(status_flags))
      else $error("set byte wrong");
  a_set_bit:
    assert property (s_exec_op(op_set_bit) |=>
      mem_wdata[st.bit_sel] && (mem_wdata & ~(`EXT_ONE << st.bit_sel)) == ($past(mem_rdata) & ~(`EXT_ONE << st.bit_sel)))
      else $error("set bit touched other bits");
  a_bit_test:
    assert property (s_exec_op(op_skip_if_nonzero_bit) |=> st.skip == $past(mem_rdata[st.bit_sel]) && !mem_wr)
      else $error("bit test skip wrong");
  a_byte_test:
    assert property (s_exec_op(op_skip_if_nonzero_byte) |=>
      mem_wr && mem_wdata == $past(mem_rdata) && st.skip == (mem_wdata != `EXT_ZERO))
      else $error("byte test wrong");
  a_far_address:
    assert property (op_ready && op_valid |=> mem_rd && mem_addr == $past(op_addr) ##1 !mem_rd ##1 mem_addr == $past(op_addr, 3))
      else $error("full address not presented");
  a_zero_flag:
    assert property (s_exec_op(op_far_or_to_accum) |=> status_flags[`EXT_FLAG_ZERO] == (accum == `EXT_ZERO))
      else $error("zero flag wrong");

endmodule

// [inc/ext_alu_consts.svh]
// Offsets, field positions, reset values and widths of the extended-memory ALU
`ifndef EXT_ALU_CONSTS_SVH
`define EXT_ALU_CONSTS_SVH

// Full data memory address: section bits above the byte offset
`define EXT_ADDR_W 11
`define EXT_PADDR_W 12

// APB register byte addresses
`define EXT_REG_ACCUM 12'h000
`define EXT_REG_FLAGS 12'h004
`define EXT_REG_STATUS 12'h008

// Flag bit positions inside the flag register
`define EXT_FLAG_W 6
`define EXT_FLAG_CARRY 0
`define EXT_FLAG_HALF 1
`define EXT_FLAG_ZERO 2
`define EXT_FLAG_RANGE 3
`define EXT_FLAG_SIGN 4
`define EXT_FLAG_CHAIN 5

// Status register fields
`define EXT_STAT_BUSY 0
`define EXT_STAT_SKIP_LO 8

// Reset values and data constants
`define EXT_ACC_RST 8'h00
`define EXT_FLAGS_RST 6'h00
`define EXT_ALL_ONES 8'hFF
`define EXT_ONE 8'h01
`define EXT_ZERO 8'h00

`endif

// [inc/ext_alu_pkg.sv]
// Types shared by the extended-memory ALU datapath
package ext_alu_pkg;

  // Operations offered by the instruction sequencer
  typedef enum logic [4:0] {
    op_far_move_load,
    op_far_move_store,
    op_far_or_to_accum,
    op_far_or_to_memory,
    op_rotate_left_byte,
    op_rotate_left_to_accum,
    op_rotate_left_thru_carry,
    op_rotate_left_thru_carry_to_accum,
    op_rotate_right_byte,
    op_rotate_right_to_accum,
    op_rotate_right_thru_carry,
    op_rotate_right_thru_carry_to_accum,
    op_sub_with_borrow_to_accum,
    op_sub_with_borrow_to_memory,
    op_subtract_to_accum,
    op_subtract_to_memory,
    op_decrement_skip_zero,
    op_decrement_skip_zero_to_accum,
    op_increment_skip_zero,
    op_increment_skip_zero_to_accum,
    op_set_byte,
    op_set_bit,
    op_skip_if_nonzero_bit,
    op_skip_if_nonzero_byte
  } op_e;

  // Execution phases
  typedef enum logic [2:0] {
    ph_idle,
    ph_read,
    ph_exec,
    ph_write,
    ph_dummy
  } phase_e;

endpackage

// [verif/ext_mem_model.sv]
// Data memory partner for the extended-memory ALU, one-cycle read latency
`timescale 1ns/1ps
`include "ext_alu_consts.svh"
module ext_mem_model (
  input wire logic clk_sys, // Core clock
  input wire logic [`EXT_ADDR_W-1:0] mem_addr, // Byte address, any section
  input wire logic mem_rd, // Read strobe
  output logic [7:0] mem_rdata, // Read data, valid the cycle after the strobe
  input wire logic mem_wr, // Write strobe
  input wire logic [7:0] mem_wdata // Write data
);
  logic [7:0] cells [0:(1<<`EXT_ADDR_W)-1];
  // Answer a read next cycle; otherwise toggle so stale data never looks valid
  always @(posedge clk_sys) begin
    if (mem_rd) begin
      mem_rdata <= cells[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr) begin
      cells[mem_addr] <= mem_wdata;
    end
  end
  initial begin
    mem_rdata = 8'h00;
  end
endmodule

// [verif/extended_memory_alu_ops_bench.sv]
// Self-checking bench: APB set-up, every operation over boundary operands
`timescale 1ns/1ps
`include "ext_alu_consts.svh"
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module extended_memory_alu_ops_bench;
  import ext_alu_pkg::*;
  logic clk_sys, reset, op_valid, op_ready, op_done, squash_next, mem_rd, mem_wr;
  op_e op_code;
  logic [`EXT_ADDR_W-1:0] op_addr, mem_addr;
  logic [2:0] op_bit;
  logic [7:0] mem_rdata, mem_wdata, accum;
  logic [`EXT_FLAG_W-1:0] status_flags;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [`EXT_PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] acc_tab [0:4] = '{8'h00, 8'h7F, 8'h80, 8'h01, 8'hA5};
  logic [7:0] mem_tab [0:4] = '{8'h00, 8'hFF, 8'h01, 8'h80, 8'h5A};
  int fails = 0;
  int num_checks = 0;
  int skips = 0;
  extended_memory_alu_ops u_dut (.clk_sys(clk_sys), .reset(reset), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit), .op_done(op_done), .squash_next(squash_next),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .accum(accum), .status_flags(status_flags), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ext_mem_model u_mem (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata));
  // Core clock, 20 ns period
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Expected result of one operation
  function automatic void predict(input op_e op, input logic [7:0] a, m, input logic [5:0] f,
    input logic [2:0] b, output logic [7:0] na, nm, output logic [5:0] nf, output logic sk);
    logic [8:0] d;
    logic [4:0] h;
    logic bw;
    na = a;
    nm = m;
    nf = f;
    sk = 1'b0;
    bw = (op == op_sub_with_borrow_to_accum || op == op_sub_with_borrow_to_memory);
    case (op)
      op_far_move_load: na = m;
      op_far_move_store: nm = a;
      op_far_or_to_accum: na = a | m;
      op_far_or_to_memory: nm = a | m;
      op_rotate_left_byte: nm = {m[6:0], m[7]};
      op_rotate_left_to_accum: na = {m[6:0], m[7]};
      op_rotate_left_thru_carry: nm = {m[6:0], f[`EXT_FLAG_CARRY]};
      op_rotate_left_thru_carry_to_accum: na = {m[6:0], f[`EXT_FLAG_CARRY]};
      op_rotate_right_byte: nm = {m[0], m[7:1]};
      op_rotate_right_to_accum: na = {m[0], m[7:1]};
      op_rotate_right_thru_carry: nm = {f[`EXT_FLAG_CARRY], m[7:1]};
      op_rotate_right_thru_carry_to_accum: na = {f[`EXT_FLAG_CARRY], m[7:1]};
      op_decrement_skip_zero: nm = m - 8'h01;
      op_decrement_skip_zero_to_accum: na = m - 8'h01;
      op_increment_skip_zero: nm = m + 8'h01;
      op_increment_skip_zero_to_accum: na = m + 8'h01;
      op_set_byte: nm = 8'hFF;
      op_set_bit: nm[b] = 1'b1;
      op_skip_if_nonzero_bit: sk = m[b];
      op_skip_if_nonzero_byte: sk = (m != 8'h00);
      default: begin
        d = {1'b0, a} - {1'b0, m} - {8'h00, bw & ~f[`EXT_FLAG_CARRY]};
        h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bw & ~f[`EXT_FLAG_CARRY]};
        nf[`EXT_FLAG_CARRY] = ~d[8];
        nf[`EXT_FLAG_HALF] = ~h[4];
        nf[`EXT_FLAG_ZERO] = (d[7:0] == 8'h00);
        nf[`EXT_FLAG_RANGE] = (a[7] ^ m[7]) & (a[7] ^ d[7]);
        nf[`EXT_FLAG_SIGN] = nf[`EXT_FLAG_RANGE] ^ d[7];
        nf[`EXT_FLAG_CHAIN] = nf[`EXT_FLAG_ZERO] & (~bw | f[`EXT_FLAG_CHAIN]);
        if (op == op_sub_with_borrow_to_memory || op == op_subtract_to_memory) begin
          nm = d[7:0];
        end else begin
          na = d[7:0];
        end
      end
    endcase
    if (op == op_rotate_left_thru_carry || op == op_rotate_left_thru_carry_to_accum) begin
      nf[`EXT_FLAG_CARRY] = m[7];
    end
    if (op == op_rotate_right_thru_carry || op == op_rotate_right_thru_carry_to_accum) begin
      nf[`EXT_FLAG_CARRY] = m[0];
    end
    if (op == op_far_or_to_accum || op == op_far_or_to_memory) begin
      nf[`EXT_FLAG_ZERO] = ((a | m) == 8'h00);
    end
    if (op >= op_decrement_skip_zero && op <= op_increment_skip_zero_to_accum) begin
      sk = ((op[0] ? na : nm) == 8'h00);
    end
  endfunction
  // One APB transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Load operands, run one operation, check timing and results
  task automatic run(input int i, input int j);
    op_e op;
    logic [7:0] na, nm;
    logic [5:0] f, nf;
    logic [2:0] b;
    logic [10:0] ad;
    logic sk, sq;
    int n;
    op = op_e'(i);
    f = j[0] ? 6'h3F : 6'h00;
    b = 3'(i + j);
    ad = {3'(j), 8'(i * 7)};
    predict(op, acc_tab[j], mem_tab[j], f, b, na, nm, nf, sk);
    u_mem.cells[ad] = mem_tab[j];
    apb(1'b1, `EXT_REG_ACCUM, {24'h0, acc_tab[j]});
    apb(1'b1, `EXT_REG_FLAGS, {26'h0, f});
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= op;
    op_addr <= ad;
    op_bit <= b;
    // Ready looked at mid-cycle, then the take edge passes
    for (n = 0; n < 20; n++) begin
      @(negedge clk_sys);
      if (op_ready === 1'b1) break;
    end
    @(posedge clk_sys);
    op_valid <= 1'b0;
    sq = 1'b0;
    for (n = 1; n < 8; n++) begin
      @(negedge clk_sys);
      sq = sq | squash_next;
      if (op_done === 1'b1) break;
    end
    skips += int'(sk);
    `CHK(n, sk ? 4 : 3, "operation length")
    `CHK(sq, sk, "dummy cycle")
    @(negedge clk_sys);
    `CHK(op_ready, 1'b1, "ready after done")
    `CHK(accum, na, "accumulator")
    `CHK(status_flags, nf, "flags")
    `CHK(u_mem.cells[ad], nm, "memory byte")
  endtask
  task automatic end_sim;
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = op_far_move_load;
    op_addr = '0;
    op_bit = 3'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, `EXT_REG_FLAGS, 32'h0);
    `CHK(rd, 32'h0, "flags after reset")
    apb(1'b1, `EXT_REG_FLAGS, 32'hFFFFFFFF);
    apb(1'b0, `EXT_REG_FLAGS, 32'h0);
    `CHK(rd, 32'h0000003F, "flags width")
    apb(1'b1, 12'h00C, 32'h12345678);
    `CHK(er, 1'b1, "unmapped write error")
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0}, "unmapped read")
    apb(1'b1, `EXT_REG_STATUS, 32'hFFFF);
    apb(1'b0, `EXT_REG_STATUS, 32'h0);
    `CHK(rd, 32'h0, "status read only")
    for (int j = 0; j < 5; j++) begin
      for (int i = 0; i < 24; i++) begin
        run(i, j);
      end
    end
    apb(1'b0, `EXT_REG_STATUS, 32'h0);
    `CHK(rd, {16'h0, 8'(skips), 8'h00}, "skip count")
    end_sim();
  end
  // Watchdog
  initial begin
    #400000;
    fails++;
    end_sim();
  end
endmodule
